/* src/isc_regs.svh */
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH

// register indices; byte address is four times the index
`define ISC_IDX_TMR      8'h32
`define ISC_IDX_DMA0     8'h34
`define ISC_IDX_DMA1     8'h36
`define ISC_IDX_EXTA     8'h38
`define ISC_IDX_EXTB     8'h3a
`define ISC_IDX_EXTC     8'h3c
`define ISC_IDX_EXTD     8'h3e
`define ISC_IDX_MODE     8'h40
`define ISC_IDX_MASK     8'h41
`define ISC_IDX_EVSTS    8'h42
`define ISC_IDX_EVMSK    8'h43
`define ISC_IDX_ACTIVE   8'h44

// control word fields
`define ISC_CTL_RST      16'h000f
`define ISC_PRI_LSB      0
`define ISC_PRI_MSB      2
`define ISC_BIT_BLOCK    3
`define ISC_BIT_LEVEL    4
`define ISC_BIT_CASC     5
`define ISC_BIT_NEST     6
`define ISC_WMASK_PLAIN  16'h000f
`define ISC_WMASK_EXTCD  16'h001f
`define ISC_WMASK_EXTAB  16'h007f
`define ISC_PRI_LOWEST   3'h7

// vector types
`define ISC_VEC_TMR0     8'h08
`define ISC_VEC_TMR1     8'h12
`define ISC_VEC_TMR2     8'h13
`define ISC_VEC_DMA0     8'h0a
`define ISC_VEC_DMA1     8'h0b
`define ISC_VEC_EXTA     8'h0c
`define ISC_VEC_EXTB     8'h0d
`define ISC_VEC_EXTC     8'h0e
`define ISC_VEC_EXTD     8'h0f

`endif

/* src/isc_pkg.sv */
package isc_pkg;
   localparam int ISC_NSRC = 9;
   // source slots, also the bit order of mask, status and event mask words
   typedef enum logic [3:0] {
      ISC_SRC_TMR0 = 4'h0,
      ISC_SRC_TMR1 = 4'h1,
      ISC_SRC_TMR2 = 4'h2,
      ISC_SRC_DMA0 = 4'h3,
      ISC_SRC_DMA1 = 4'h4,
      ISC_SRC_EXTA = 4'h5,
      ISC_SRC_EXTB = 4'h6,
      ISC_SRC_EXTC = 4'h7,
      ISC_SRC_EXTD = 4'h8
   } isc_src_type;
   // register slots behind the decoder
   typedef enum logic [3:0] {
      ISC_SLOT_MODE   = 4'h9,
      ISC_SLOT_MASK   = 4'ha,
      ISC_SLOT_EVSTS  = 4'hb,
      ISC_SLOT_EVMSK  = 4'hc,
      ISC_SLOT_ACTIVE = 4'hd,
      ISC_SLOT_NONE   = 4'hf
   } isc_slot_type;
   typedef logic [15:0] isc_word_type;
   typedef logic [ISC_NSRC-1:0] isc_vec_type;
endpackage

/* src/isc_source_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.svh"
// Functional notes
// - line c vector 0eh, line d 0fh
// - line a vector 0ch, line b 0dh
// - timers vectors 08h,12h,13h, shared master register
// - dma0 vector 0ah, dma1 vector 0bh
// - cascade turns pins c/d into acknowledges
// - all control registers reset to 000fh
// - bit 4 set level, clear rising edge
// - bit 3 set blocks the source
// - mask bits mirrored in mask register
// - bits 2-0 priority, seven lowest
// - bit 6 enables special nesting, lines a/b
// - bit 5 enables cascade, lines a/b
// - slave mode: per-timer registers 32h,38h,3ah
// - master shared timer block masks all timers
// - dma pins act as irq or dma request
// - dma registers same in slave mode
// - priority 000b highest, numeric order
module isc_source_ctrl #(
   parameter int AW = 12
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [AW-1:0]         paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // external request pins
   input  wire logic                  ext_irq_line_a,
   input  wire logic                  ext_irq_line_b,
   input  wire logic                  ext_irq_line_c,
   input  wire logic                  ext_irq_line_d,
   input  wire logic                  ext_irq_line_e,
   input  wire logic                  ext_irq_line_f,
   // acknowledge outputs on pins c and d
   output logic                       ack_out_a,
   output logic                       ack_out_a_oe,
   output logic                       ack_out_b,
   output logic                       ack_out_b_oe,
   // on-chip sources
   input  wire logic [2:0]            timer_expire,
   input  wire logic [1:0]            dma_done,
   input  wire logic [1:0]            dma_pin_is_irq,
   output logic [1:0]                 dma_pin_request,
   // core side
   input  wire logic                  core_ack,
   output logic                       irq_request,
   output logic [7:0]                 irq_vector_type,
   output logic [2:0]                 irq_urgency_level,
   output logic [1:0]                 special_nested_enable,
   output logic                       irq
);
   import isc_pkg::*;

   // control words, one per source slot
   isc_word_type ctl_reg [ISC_NSRC];
   logic         slave_mode_reg;
   isc_vec_type  pend_reg;
   isc_vec_type  evsts_reg;
   isc_vec_type  evmsk_reg;
   logic [3:0]   sel_reg;
   logic [5:0]   pin_meta_reg;
   logic [5:0]   pin_sync_reg;
   logic [5:0]   pin_prev_reg;

   function automatic logic [3:0] decode_slot(input logic [7:0] idx, input logic slave);
      logic [3:0] s;
      s = ISC_SLOT_NONE;
      unique case (idx)
         `ISC_IDX_TMR:    s = ISC_SRC_TMR0;
         `ISC_IDX_DMA0:   s = ISC_SRC_DMA0;
         `ISC_IDX_DMA1:   s = ISC_SRC_DMA1;
         `ISC_IDX_EXTA:   s = slave ? ISC_SRC_TMR1 : ISC_SRC_EXTA;
         `ISC_IDX_EXTB:   s = slave ? ISC_SRC_TMR2 : ISC_SRC_EXTB;
         `ISC_IDX_EXTC:   s = ISC_SRC_EXTC;
         `ISC_IDX_EXTD:   s = ISC_SRC_EXTD;
         `ISC_IDX_MODE:   s = ISC_SLOT_MODE;
         `ISC_IDX_MASK:   s = ISC_SLOT_MASK;
         `ISC_IDX_EVSTS:  s = ISC_SLOT_EVSTS;
         `ISC_IDX_EVMSK:  s = ISC_SLOT_EVMSK;
         `ISC_IDX_ACTIVE: s = ISC_SLOT_ACTIVE;
         default:         s = ISC_SLOT_NONE;
      endcase
      return s;
   endfunction

   // writable bits per slot; all else reads zero
   function automatic isc_word_type write_mask(input int s);
      if (s == ISC_SRC_EXTA || s == ISC_SRC_EXTB) begin
         return `ISC_WMASK_EXTAB;
      end else if (s == ISC_SRC_EXTC || s == ISC_SRC_EXTD) begin
         return `ISC_WMASK_EXTCD;
      end
      return `ISC_WMASK_PLAIN;
   endfunction

   function automatic logic [7:0] vector_of(input logic [3:0] s);
      logic [7:0] v;
      v = `ISC_VEC_TMR0;
      unique case (s)
         ISC_SRC_TMR0: v = `ISC_VEC_TMR0;
         ISC_SRC_TMR1: v = `ISC_VEC_TMR1;
         ISC_SRC_TMR2: v = `ISC_VEC_TMR2;
         ISC_SRC_DMA0: v = `ISC_VEC_DMA0;
         ISC_SRC_DMA1: v = `ISC_VEC_DMA1;
         ISC_SRC_EXTA: v = `ISC_VEC_EXTA;
         ISC_SRC_EXTB: v = `ISC_VEC_EXTB;
         ISC_SRC_EXTC: v = `ISC_VEC_EXTC;
         ISC_SRC_EXTD: v = `ISC_VEC_EXTD;
         default:      v = `ISC_VEC_TMR0;
      endcase
      return v;
   endfunction

   // apb decode
   wire       addr_ok   = (paddr[1:0] == 2'b00) && (paddr[AW-1:10] == '0);
   wire [3:0] slot      = addr_ok ? decode_slot(paddr[9:2], slave_mode_reg) : ISC_SLOT_NONE;
   wire       setup     = psel && !penable;
   wire       wr_fire   = psel && penable && pready && pwrite && !pslverr;
   wire       wr_low    = pstrb[0];
   wire       wr_high   = pstrb[1];
   // write strobes per register class; status and event mask want both lanes
   wire       wr_word   = wr_fire && wr_low;
   wire       wr_mode   = wr_word && (slot == ISC_SLOT_MODE);
   wire       wr_mirror = wr_word && (slot == ISC_SLOT_MASK);
   wire       wr_evmsk  = wr_word && wr_high && (slot == ISC_SLOT_EVMSK);
   wire       wr_evsts  = wr_word && wr_high && (slot == ISC_SLOT_EVSTS);


   // effective control word per source; master timers share slot 0
   isc_word_type eff_ctl [ISC_NSRC];
   genvar g;
   generate
      for (g = 0; g < ISC_NSRC; g++) begin : g_eff
         if (g == ISC_SRC_TMR1 || g == ISC_SRC_TMR2) begin : g_tmr
            assign eff_ctl[g] = slave_mode_reg ? ctl_reg[g] : ctl_reg[ISC_SRC_TMR0];
         end else begin : g_other
            assign eff_ctl[g] = ctl_reg[g];
         end
      end
   endgenerate

   wire casc_a = ctl_reg[ISC_SRC_EXTA][`ISC_BIT_CASC];
   wire casc_b = ctl_reg[ISC_SRC_EXTB][`ISC_BIT_CASC];

   // pins 0..5 = lines a..f after two flops
   wire [5:0] pin_rise = pin_sync_reg & ~pin_prev_reg;

   // raw events, rising edges or on-chip pulses
   isc_vec_type raw_evt;
   isc_vec_type level_req;
   assign raw_evt[2:0] = timer_expire;
   assign raw_evt[ISC_SRC_DMA0] = dma_pin_is_irq[0] ? pin_rise[4] : dma_done[0];
   assign raw_evt[ISC_SRC_DMA1] = dma_pin_is_irq[1] ? pin_rise[5] : dma_done[1];
   assign raw_evt[ISC_SRC_EXTA] = pin_rise[0];
   assign raw_evt[ISC_SRC_EXTB] = pin_rise[1];
   // pins c/d carry acknowledges while cascaded, so no requests there
   assign raw_evt[ISC_SRC_EXTC] = pin_rise[2] && !casc_a;
   assign raw_evt[ISC_SRC_EXTD] = pin_rise[3] && !casc_b;
   assign level_req[4:0] = '0;
   assign level_req[ISC_SRC_EXTA] = pin_sync_reg[0];
   assign level_req[ISC_SRC_EXTB] = pin_sync_reg[1];
   assign level_req[ISC_SRC_EXTC] = pin_sync_reg[2] && !casc_a;
   assign level_req[ISC_SRC_EXTD] = pin_sync_reg[3] && !casc_b;

   // level mode relies on the requester holding the line until acknowledged
   // limitation: a level line lags its pin by the two sync flops, so it may
   // ask once more right after its acknowledge
   isc_vec_type is_level;
   isc_vec_type blocked;
   isc_vec_type active_req;
   generate
      for (g = 0; g < ISC_NSRC; g++) begin : g_req
         if (g >= ISC_SRC_EXTA) begin : g_ext
            assign is_level[g] = eff_ctl[g][`ISC_BIT_LEVEL];
         end else begin : g_int
            assign is_level[g] = 1'b0;
         end
         assign blocked[g]    = eff_ctl[g][`ISC_BIT_BLOCK];
         assign active_req[g] = (is_level[g] ? level_req[g] : pend_reg[g]) && !blocked[g];
      end
   endgenerate

   // winner: smallest priority code, ties to the lower slot
   function automatic logic [3:0] pick(input isc_vec_type req, input logic [2:0] pr [ISC_NSRC]);
      logic [3:0] best;
      logic [2:0] best_pr;
      best = ISC_SLOT_NONE;
      best_pr = `ISC_PRI_LOWEST;
      for (int i = 0; i < ISC_NSRC; i++) begin
         if (req[i] && (best == ISC_SLOT_NONE || pr[i] < best_pr)) begin
            best = 4'(i);
            best_pr = pr[i];
         end
      end
      return best;
   endfunction

   logic [2:0] pri [ISC_NSRC];
   generate
      for (g = 0; g < ISC_NSRC; g++) begin : g_pri
         assign pri[g] = eff_ctl[g][`ISC_PRI_MSB:`ISC_PRI_LSB];
      end
   endgenerate
   wire [3:0] winner   = pick(active_req, pri);
   wire       have_win = (winner != ISC_SLOT_NONE);
   wire       ack_hit  = core_ack && (sel_reg != ISC_SLOT_NONE);

   // mask mirror view; master timers show the shared bit
   isc_vec_type mask_view;
   generate
      for (g = 0; g < ISC_NSRC; g++) begin : g_mv
         assign mask_view[g] = eff_ctl[g][`ISC_BIT_BLOCK];
      end
   endgenerate

   isc_word_type rd_word;
   always_comb begin
      rd_word = '0;
      if (slot < 4'(ISC_NSRC)) begin
         rd_word = ctl_reg[slot] & write_mask(int'(slot));
      end else if (slot == ISC_SLOT_MODE) begin
         rd_word = {15'h0000, slave_mode_reg};
      end else if (slot == ISC_SLOT_MASK) begin
         rd_word = {7'h00, mask_view};
      end else if (slot == ISC_SLOT_EVSTS) begin
         rd_word = {7'h00, evsts_reg};
      end else if (slot == ISC_SLOT_EVMSK) begin
         rd_word = {7'h00, evmsk_reg};
      end else if (slot == ISC_SLOT_ACTIVE) begin
         rd_word = {4'h0, sel_reg, vector_of(sel_reg)};
      end
   end

   // apb response registered at setup; access phase is one cycle while clk_en stays high
   wire        pready_next  = setup;
   wire        pslverr_next = setup && (slot == ISC_SLOT_NONE);
   // read data frozen at setup so a late address change cannot tear it
   wire [31:0] prdata_next  = pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (clk_en) begin
         pready  <= pready_next;
         pslverr <= pslverr_next;
         if (setup) begin
            prdata <= prdata_next;
         end
      end
   end

   // control words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < ISC_NSRC; i++) begin
            ctl_reg[i] <= `ISC_CTL_RST;
         end
         slave_mode_reg <= 1'b0;
         evmsk_reg      <= '0;
      end else if (clk_en && wr_fire) begin
         for (int i = 0; i < ISC_NSRC; i++) begin
            if (wr_word && slot == 4'(i)) begin
               ctl_reg[i] <= pwdata[15:0] & write_mask(i);
            end else if (wr_mirror) begin
               // master timers follow the shared bit only
               if (slave_mode_reg || i == ISC_SRC_TMR0 || i > ISC_SRC_TMR2) begin
                  ctl_reg[i][`ISC_BIT_BLOCK] <= pwdata[i];
               end
            end
         end
         if (wr_mode) begin
            slave_mode_reg <= pwdata[0];
         end
         if (wr_evmsk) begin
            evmsk_reg <= pwdata[ISC_NSRC-1:0];
         end
      end
   end

   // pin synchronisers and edge history; the second and third flops feed logic, the first feeds none
   wire [5:0] pin_raw = {ext_irq_line_f, ext_irq_line_e, ext_irq_line_d,
                         ext_irq_line_c, ext_irq_line_b, ext_irq_line_a};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end else if (clk_en) begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // edge latches: a new edge beats an acknowledge in the same cycle
   isc_vec_type ack_vec;
   assign ack_vec = ack_hit ? (isc_vec_type'(1) << sel_reg) : '0;
   wire [8:0] evsts_w1c = wr_evsts ? pwdata[ISC_NSRC-1:0] : '0;
   isc_vec_type pend_next;
   isc_vec_type evsts_next;
   assign pend_next  = (pend_reg & ~ack_vec) | raw_evt;
   // a blocked source still latches its edge but never flags status
   assign evsts_next = (evsts_reg & ~evsts_w1c) | (raw_evt & ~blocked);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg  <= '0;
         evsts_reg <= '0;
      end else if (clk_en) begin
         pend_reg  <= pend_next;
         evsts_reg <= evsts_next;
      end
   end

   // core request, vector and cascade acknowledge
   // one idle cycle after an ack so the cleared latch is seen
   wire       grant_live   = have_win && !ack_hit;
   wire [3:0] sel_next     = ack_hit ? ISC_SLOT_NONE : winner;
   wire [7:0] vector_next  = have_win ? vector_of(winner) : 8'h00;
   // urgency tracks the request so an idle output always reads lowest
   wire [2:0] urgency_next = grant_live ? pri[winner] : `ISC_PRI_LOWEST;
   wire       ack_a_next   = ack_hit && (sel_reg == ISC_SRC_EXTA) && casc_a;
   wire       ack_b_next   = ack_hit && (sel_reg == ISC_SRC_EXTB) && casc_b;
   wire [1:0] nest_next    = {ctl_reg[ISC_SRC_EXTB][`ISC_BIT_NEST],
                              ctl_reg[ISC_SRC_EXTA][`ISC_BIT_NEST]};
   // pins in dma mode pass straight through as requests
   wire [1:0] dma_req_next = ~dma_pin_is_irq & pin_sync_reg[5:4];
   wire       irq_next     = |(evsts_reg & ~evmsk_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg               <= ISC_SLOT_NONE;
         irq_request           <= 1'b0;
         irq_vector_type       <= '0;
         irq_urgency_level     <= `ISC_PRI_LOWEST;
         ack_out_a             <= 1'b0;
         ack_out_b             <= 1'b0;
         ack_out_a_oe          <= 1'b0;
         ack_out_b_oe          <= 1'b0;
         special_nested_enable <= '0;
         dma_pin_request       <= '0;
         irq                   <= 1'b0;
      end else if (clk_en) begin
         sel_reg               <= sel_next;
         irq_request           <= grant_live;
         irq_vector_type       <= vector_next;
         irq_urgency_level     <= urgency_next;
         ack_out_a             <= ack_a_next;
         ack_out_b             <= ack_b_next;
         ack_out_a_oe          <= casc_a;
         ack_out_b_oe          <= casc_b;
         special_nested_enable <= nest_next;
         dma_pin_request       <= dma_req_next;
         irq                   <= irq_next;
      end
   end

endmodule // isc_source_ctrl
`default_nettype wire

/* testbench/isc_ext_src.sv */
`timescale 1ns/1ps
`default_nettype none
module isc_ext_src (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // bench commands and core acknowledge
   input  wire logic [5:0] raise,
   input  wire logic       core_ack,
   input  wire logic [7:0] irq_vector_type,
   // request lines a..f
   output logic [5:0]      line
);
   // vector that answers each line
   localparam logic [7:0] VEC [6] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h0a, 8'h0b};
   // a line is never dropped early, only by its own acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line <= '0;
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (raise[i]) begin
               line[i] <= 1'b1;
            end else if (core_ack && irq_vector_type == VEC[i]) begin
               line[i] <= 1'b0;
            end
         end
      end
   end
endmodule // isc_ext_src
`default_nettype wire

/* testbench/isc_source_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module isc_chk (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       clk_en,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       core_ack,
   input wire logic       irq_request,
   input wire logic [7:0] irq_vector_type,
   input wire logic [2:0] irq_urgency_level,
   input wire logic       irq,
   input wire logic       ack_out_a,
   input wire logic       ack_out_a_oe,
   input wire logic       ack_out_b,
   input wire logic       ack_out_b_oe,
   input wire logic [1:0] dma_pin_is_irq,
   input wire logic [1:0] dma_pin_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst_vals;
      $rose(presetn) |-> irq_urgency_level == 3'h7 && !irq && !irq_request && !ack_out_a_oe;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs off after reset");
   property p_idle_urg;
      !irq_request |-> irq_urgency_level == 3'h7;
   endproperty
   a_idle_urg: assert property (p_idle_urg) else $error("idle urgency not lowest");
   property p_vec_set;
      irq_request |-> irq_vector_type inside {8'h08, 8'h12, 8'h13, 8'h0a, 8'h0b,
                                              8'h0c, 8'h0d, 8'h0e, 8'h0f};
   endproperty
   a_vec_set: assert property (p_vec_set) else $error("vector type unknown");
   property p_ack_a;
      ack_out_a |-> $past(core_ack) && $past(irq_vector_type) == 8'h0c && ack_out_a_oe;
   endproperty
   a_ack_a: assert property (p_ack_a) else $error("stray acknowledge a");
   property p_ack_b;
      ack_out_b |-> $past(core_ack) && $past(irq_vector_type) == 8'h0d && ack_out_b_oe;
   endproperty
   a_ack_b: assert property (p_ack_b) else $error("stray acknowledge b");
   property p_ack_short;
      ack_out_a || ack_out_b |=> !ack_out_a && !ack_out_b;
   endproperty
   a_ack_short: assert property (p_ack_short) else $error("acknowledge too long");
   property p_dma_pin;
      $past(clk_en) |-> ($past(dma_pin_is_irq) & dma_pin_request) == 2'b00;
   endproperty
   a_dma_pin: assert property (p_dma_pin) else $error("dma request in irq mode");
   property p_drop;
      core_ack && irq_request |=> !irq_request;
   endproperty
   a_drop: assert property (p_drop) else $error("request kept after acknowledge");
   property p_pready;
      psel && !penable |=> pready;
   endproperty
   a_pready: assert property (p_pready) else $error("no answer after setup");
endmodule // isc_chk
bind isc_source_ctrl isc_chk isc_chk_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pready,
   .core_ack, .irq_request, .irq_vector_type, .irq_urgency_level, .irq, .ack_out_a,
   .ack_out_a_oe, .ack_out_b, .ack_out_b_oe, .dma_pin_is_irq, .dma_pin_request);
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic             pclk, presetn, psel, penable, pwrite, core_ack, exp_irq, er;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, rd;
   logic [3:0]       pstrb;
   logic [5:0]       raise;
   logic [2:0]       timer_expire;
   logic [1:0]       dma_done, dma_pin_is_irq;
   wire logic        pready, pslverr, irq_request, irq, ack_out_a, ack_out_a_oe;
   wire logic        ack_out_b, ack_out_b_oe;
   wire logic [31:0] prdata;
   wire logic [7:0]  irq_vector_type;
   wire logic [2:0]  irq_urgency_level;
   wire logic [1:0]  dma_pin_request, special_nested_enable;
   wire logic [5:0]  line;
   // pins c/d carry the acknowledges while cascaded
   wire logic        pin_c = ack_out_a_oe ? ack_out_a : line[2];
   wire logic        pin_d = ack_out_b_oe ? ack_out_b : line[3];
   int               err_count, checked, cyc;
   localparam logic [11:0] ADR [7] = '{12'h0c8, 12'h0d0, 12'h0d8, 12'h0e0, 12'h0e8, 12'h0f0,
                                       12'h0f8};
   localparam logic [15:0] WM [7] = '{16'hf, 16'hf, 16'hf, 16'h7f, 16'h7f, 16'h1f, 16'h1f};
   localparam logic [2:0] CP [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
   // sources: lines a..f, timers 0..2, dma 0..1
   localparam logic [7:0] VEC [11] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h0a, 8'h0b, 8'h08,
                                       8'h12, 8'h13, 8'h0a, 8'h0b};
   localparam logic [2:0] PRI [11] = '{3'h4, 3'h5, 3'h6, 3'h0, 3'h2, 3'h3, 3'h1, 3'h1,
                                       3'h1, 3'h2, 3'h3};
   isc_source_ctrl #(.AW(12)) isc_source_ctrl_inst (.pclk, .presetn, .clk_en(1'b1), .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
      .ext_irq_line_a(line[0]), .ext_irq_line_b(line[1]), .ext_irq_line_c(pin_c),
      .ext_irq_line_d(pin_d), .ext_irq_line_e(line[4]), .ext_irq_line_f(line[5]),
      .ack_out_a, .ack_out_a_oe, .ack_out_b, .ack_out_b_oe, .timer_expire, .dma_done,
      .dma_pin_is_irq, .dma_pin_request, .core_ack, .irq_request, .irq_vector_type,
      .irq_urgency_level, .special_nested_enable, .irq);
   isc_ext_src isc_ext_src_inst (.pclk, .presetn, .raise, .core_ack, .irq_vector_type, .line);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fire(input logic [10:0] s);
      @(posedge pclk);
      raise <= s[5:0];
      timer_expire <= s[8:6];
      dma_done <= s[10:9];
      @(posedge pclk);
      raise <= '0;
      timer_expire <= '0;
      dma_done <= '0;
   endtask
   // serve one request, then clear all nine event status bits
   task automatic take(input logic [7:0] v, input logic [2:0] p);
      do @(posedge pclk); while (irq_request !== 1'b1);
      chk(irq_vector_type, v);
      chk(irq_urgency_level, p);
      chk(irq, exp_irq);
      core_ack <= 1'b1;
      @(posedge pclk);
      core_ack <= 1'b0;
      apb(1'b1, 12'h108, 32'h1ff);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, core_ack, raise, timer_expire, dma_done} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      dma_pin_is_irq = 2'b11;
      exp_irq = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, ADR[i], 32'h0);
         chk(rd, 32'h000f);
         apb(1'b1, ADR[i], 32'hffffffff);
         apb(1'b0, ADR[i], 32'h0);
         chk(rd, {16'h0, WM[i]});
      end
      chk({ack_out_b_oe, ack_out_a_oe, special_nested_enable}, 4'hf);
      apb(1'b0, 12'h104, 32'h0);
      chk(rd, 32'h1ff);
      apb(1'b0, 12'h0a0, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 7; i++) apb(1'b1, ADR[i], {29'h0, CP[i]});
      for (int i = 0; i < 11; i++) begin
         // dma done pulses only count while the pins act as dma requests
         if (i == 9) begin
            dma_pin_is_irq <= 2'b00;
         end
         fire(11'h1 << i);
         take(VEC[i], PRI[i]);
      end
      $display("test vectors done");
      // event mask hides the summary line, requests still flow
      apb(1'b1, 12'h10c, 32'h1ff);
      exp_irq = 1'b0;
      apb(1'b1, ADR[0], 32'h5);
      fire(11'h240);
      take(8'h0a, 3'h2);
      take(8'h08, 3'h5);
      apb(1'b1, 12'h10c, 32'h0);
      exp_irq = 1'b1;
      $display("test priority done");
      apb(1'b1, ADR[3], 32'h24);
      apb(1'b1, ADR[4], 32'h25);
      fire(11'h1);
      take(8'h0c, 3'h4);
      fire(11'h2);
      take(8'h0d, 3'h5);
      apb(1'b1, ADR[3], 32'hf);
      $display("test cascade done");
      apb(1'b1, ADR[0], 32'hd);
      apb(1'b1, ADR[4], 32'hb);
      fire(11'h1c2);
      repeat (12) @(posedge pclk);
      chk({irq_request, irq}, 2'b00);
      apb(1'b0, 12'h104, 32'h0);
      chk(rd, 32'h067);
      apb(1'b1, 12'h104, 32'h0e7);
      apb(1'b0, ADR[5], 32'h0);
      chk(rd, 32'h000e);
      $display("test blocking done");
      dma_pin_is_irq <= 2'b01;
      fire(11'h20);
      repeat (8) @(posedge pclk);
      chk({irq_request, dma_pin_request}, 3'b010);
      $display("test dma pin done");
      // slave mode: slot of line a becomes timer 1, whose edge is still pending
      apb(1'b1, 12'h100, 32'h1);
      apb(1'b1, ADR[3], 32'h2);
      fire(11'h080);
      repeat (2) @(posedge pclk);
      take(8'h12, 3'h2);
      apb(1'b0, ADR[3], 32'h0);
      chk(rd, 32'h0002);
      apb(1'b0, ADR[1], 32'h0);
      chk(rd, 32'h0002);
      apb(1'b1, 12'h100, 32'h0);
      apb(1'b0, ADR[3], 32'h0);
      chk(rd, 32'h000f);
      $display("test slave mode done");
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
